// ==== src/contactless_status_flags.sv ====
// status register bank of the contactless unit with apb slave and event interrupt
`default_nettype none
module contactless_status_flags
   import status_flags_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  comm_irq_sources,
   input  wire logic [7:0]  comm_irq_enables,
   input  wire logic [7:0]  misc_irq_sources,
   input  wire logic [7:0]  misc_irq_enables,
   input  wire logic [7:0]  group1_select,
   input  wire logic        cpu_irq_enable_group1,
   input  wire logic        cpu_irq_enable_group0,
   input  wire logic        checksum_busy,
   input  wire logic        checksum_result_zero,
   input  wire logic        checksum_compute_cmd,
   input  wire logic        checksum_finish,
   input  wire logic        countdown_enable,
   input  wire logic        countdown_gate,
   input  wire logic        field_detect_pin,
   input  wire logic [6:0]  queue_fill_count,
   input  wire logic [5:0]  fill_threshold,
   output logic             cpu_irq_group1,
   output logic             cpu_irq_group0,
   output logic             irq
);
   logic [7:0] status_d;
   logic [7:0] status_q;
   logic [7:0] event_q;
   logic [7:0] mask_q;
   logic [7:0] prev_q;
   logic       crc_zero_q;
   logic       crc_done_q;
   logic       field_present;
   logic       queue_nearly_full;
   logic       queue_nearly_empty;
   logic       irq_group1_pending;
   logic       irq_group0_pending;
   logic       access;
   logic       wr_status;
   logic       wr_mask;

   function automatic logic any_pending(input logic [7:0] src, input logic [7:0] en, input logic [7:0] sel);
      any_pending = |(src & en & sel);
   endfunction : any_pending

   pin_sync u_field_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (field_detect_pin),
      .dout    (field_present)
   );

   fill_compare u_fill (
      .queue_fill_count   (queue_fill_count),
      .fill_threshold     (fill_threshold),
      .queue_nearly_full  (queue_nearly_full),
      .queue_nearly_empty (queue_nearly_empty)
   );

   // group-1 sources are those picked by group1_select, the rest are group 0
   assign irq_group1_pending = any_pending(comm_irq_sources, comm_irq_enables, group1_select)
                             | any_pending(misc_irq_sources, misc_irq_enables, group1_select);
   assign irq_group0_pending = any_pending(comm_irq_sources, comm_irq_enables, ~group1_select)
                             | any_pending(misc_irq_sources, misc_irq_enables, ~group1_select);

   // checksum flags: zero flag low while busy, done flag only for the standalone command
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crc_zero_q <= status_reset[bit_crc_zero];
         crc_done_q <= status_reset[bit_crc_done];
      end else begin
         if (checksum_busy) begin
            crc_zero_q <= 1'b0;
         end else if (checksum_finish) begin
            crc_zero_q <= checksum_result_zero;
         end
         if (checksum_busy && checksum_compute_cmd) begin
            crc_done_q <= 1'b0;
         end else if (checksum_finish && checksum_compute_cmd) begin
            crc_done_q <= 1'b1;
         end
      end
   end

   // the gate input is deliberately unused: running follows the enable only
   always_comb begin
      status_d               = 8'h00;
      status_d[bit_irq1]     = irq_group1_pending;
      status_d[bit_crc_zero] = crc_zero_q;
      status_d[bit_crc_done] = crc_done_q;
      status_d[bit_irq0]     = irq_group0_pending;
      status_d[bit_running]  = countdown_enable;
      status_d[bit_field]    = field_present;
      status_d[bit_hi]       = queue_nearly_full;
      status_d[bit_lo]       = queue_nearly_empty;
   end

   // recomputed every cycle, no bus path writes it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_q <= status_reset;
      end else begin
         status_q <= status_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_irq_group1 <= 1'b0;
         cpu_irq_group0 <= 1'b0;
      end else begin
         cpu_irq_group1 <= irq_group1_pending & cpu_irq_enable_group1;
         cpu_irq_group0 <= irq_group0_pending & cpu_irq_enable_group0;
      end
   end

   assign access    = psel & penable;
   assign wr_status = access & pwrite & pstrb[0] & (paddr == irq_status_addr);
   assign wr_mask   = access & pwrite & pstrb[0] & (paddr == irq_mask_addr);

   // rising edges of status bits are the events; set beats write-one-clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q  <= status_reset;
         event_q <= 8'h00;
      end else begin
         prev_q <= status_q;
         if (wr_status) begin
            event_q <= (event_q & ~pwdata[7:0]) | (status_q & ~prev_q);
         end else begin
            event_q <= event_q | (status_q & ~prev_q);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= mask_reset;
      end else if (wr_mask) begin
         mask_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(event_q & mask_q);
      end
   end

   // zero-wait slave; read data registered in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            case (paddr)
               status_one_addr: begin
                  prdata  <= {24'h000000, status_q};
                  pslverr <= pwrite;
               end
               irq_status_addr: prdata <= {24'h000000, event_q};
               irq_mask_addr:   prdata <= {24'h000000, mask_q};
               default: begin
                  prdata  <= 32'h0000_0000;
                  pslverr <= 1'b1;
               end
            endcase
         end
      end
   end
endmodule : contactless_status_flags
`default_nettype wire

// ==== src/fill_compare.sv ====
// watermark comparisons of queue fill count against threshold
`default_nettype none
module fill_compare
   import status_flags_pkg::*;
(
   input  wire logic [6:0] queue_fill_count,
   input  wire logic [5:0] fill_threshold,
   output logic            queue_nearly_full,
   output logic            queue_nearly_empty
);
   logic [6:0] room;
   // count is clamped to the depth so room never wraps
   always_comb begin
      room = (queue_fill_count > queue_depth) ? 7'h00 : 7'(queue_depth - queue_fill_count);
      queue_nearly_full  = room <= {1'b0, fill_threshold};
      queue_nearly_empty = queue_fill_count <= {1'b0, fill_threshold};
   end
endmodule : fill_compare
`default_nettype wire

// ==== src/pin_sync.sv ====
// two-flop synchroniser for asynchronous pin levels
`default_nettype none
module pin_sync
   import status_flags_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic din,
   output logic      dout
);
   logic meta_q;
   logic sync_q;
   // first stage feeds only the second stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end
   assign dout = sync_q;
endmodule : pin_sync
`default_nettype wire

// ==== src/status_flags_pkg.sv ====
// package: offsets, fields and constants of the contactless status block
// What this block does
// - bit 7 reads 1 when any enabled group-1 source pends; cpu irq needs its enable
// - bit 4 reads 1 when any enabled group-0 source pends; cpu irq needs its enable
// - bit 6 drops while checksum calculates, rises when finished result is zero
// - bit 5 set when a standalone checksum compute command has finished
// - bit 3 reads 1 while the countdown timer runs
// - in gated mode bit 3 follows only the timer enable, not the gate
// - bit 2 shows the live field detector output, not latched
// - bit 1 is 1 when 64 minus fill count is at most the threshold
// - bit 0 is 1 when fill count is at most the threshold
`default_nettype none
package status_flags_pkg;
   localparam logic [15:0] status_one_offset = 16'h6337;
   localparam logic [15:0] irq_status_offset = 16'h0000;
   localparam logic [15:0] irq_mask_offset   = 16'h0004;
   localparam logic [31:0] status_one_addr   = {14'h0000, status_one_offset, 2'h0};
   localparam logic [31:0] irq_status_addr   = 32'h0000_0000;
   localparam logic [31:0] irq_mask_addr     = 32'h0000_0004;
   localparam int bit_irq1      = 7;
   localparam int bit_crc_zero  = 6;
   localparam int bit_crc_done  = 5;
   localparam int bit_irq0      = 4;
   localparam int bit_running   = 3;
   localparam int bit_field     = 2;
   localparam int bit_hi        = 1;
   localparam int bit_lo        = 0;
   localparam logic [7:0] status_reset = 8'h21;
   localparam logic [7:0] mask_reset   = 8'h00;
   localparam logic [6:0] queue_depth  = 7'h40;
   localparam int sync_stages   = 2;
endpackage : status_flags_pkg
`default_nettype wire

// ==== verif/cpu_model.sv ====
// processor side model issuing apb transfers
`default_nettype none
module cpu_model (
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [31:0]      paddr,
   output logic [31:0]      pwdata,
   output logic [3:0]       pstrb,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
   // no cycle count assumed: only the bench timeout ends a wait
   task xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r, output logic e);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata, pstrb} <= {1'b1, 1'b0, w, a, d, 4'hf};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : cpu_model
`default_nettype wire

// ==== verif/status_flags_sva.sv ====
// checker for the contactless status block ports
`default_nettype none
module status_flags_sva import status_flags_pkg::*; (
   input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
   input wire logic [31:0] paddr, pwdata, prdata,
   input wire logic [3:0] pstrb,
   input wire logic [7:0] comm_irq_sources, comm_irq_enables, misc_irq_sources, misc_irq_enables,
   input wire logic [7:0] group1_select,
   input wire logic cpu_irq_enable_group1, cpu_irq_enable_group0, cpu_irq_group1, cpu_irq_group0, irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic [7:0] act = (comm_irq_sources & comm_irq_enables) | (misc_irq_sources & misc_irq_enables);
   wire logic p1 = |(act & group1_select);
   wire logic p0 = |(act & ~group1_select);
   sequence setup_s; psel && !penable; endsequence
   sequence done_s; psel && penable && pready; endsequence
   a_ready_next: assert property (setup_s |=> pready && penable) else $error("no answer after setup");
   a_status_ro: assert property (done_s and pwrite && paddr == status_one_addr |-> pslverr)
      else $error("status write not refused");
   a_grp1_on: assert property ((p1 && cpu_irq_enable_group1)[*3] |-> cpu_irq_group1)
      else $error("group1 irq missing");
   a_grp1_off: assert property ((!cpu_irq_enable_group1)[*2] |-> !cpu_irq_group1)
      else $error("group1 irq while disabled");
   a_grp0_on: assert property ((p0 && cpu_irq_enable_group0)[*3] |-> cpu_irq_group0)
      else $error("group0 irq missing");
   a_grp0_off: assert property ((!p0)[*3] |-> !cpu_irq_group0) else $error("group0 irq without source");
   a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
   a_mask_clear: assert property (done_s and pwrite && paddr == irq_mask_addr && pwdata[7:0] == 8'h00
      |-> ##[1:2] !irq) else $error("irq with empty mask");
   a_unmapped_zero: assert property (done_s and !pwrite && pslverr |-> prdata == 32'h0)
      else $error("error read not zero");
endmodule : status_flags_sva
bind contactless_status_flags status_flags_sva chk (.*);
`default_nettype wire

// ==== verif/tb_top.sv ====
// self-checking testbench of the contactless status block
`default_nettype none
module tb_top import status_flags_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 0, presetn = 0, psel, penable, pwrite, pready, pslverr, err, cpu_irq_group1, cpu_irq_group0, irq;
   logic [31:0] paddr, pwdata, prdata, rdv;
   logic [3:0] pstrb;
   logic [7:0] comm_irq_sources = 0, comm_irq_enables = 0, misc_irq_sources = 0, misc_irq_enables = 0;
   logic [7:0] group1_select = 0;
   logic cpu_irq_enable_group1 = 0, cpu_irq_enable_group0 = 0, checksum_busy = 0, checksum_result_zero = 0;
   logic checksum_compute_cmd = 0, checksum_finish = 0, countdown_enable = 0, countdown_gate = 0;
   logic field_detect_pin = 0;
   logic [6:0] queue_fill_count = 0;
   logic [5:0] fill_threshold = 0;
   int failures = 0, check_count = 0, cyc = 0;
   contactless_status_flags DUT (.*);
   cpu_model cpu (.*);
   always #25 pclk = ~pclk;
   task stop_test;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : stop_test
   always @(posedge pclk) if (++cyc == 20000) begin failures++; stop_test; end
   task chk(input string n, input logic [31:0] e, s);
      check_count++;
      if (s !== e) begin failures++; $display("MISMATCH %s exp %h got %h", n, e, s); end
   endtask : chk
   // settle time covers the pin synchroniser
   task st; repeat (4) @(posedge pclk); cpu.xfer(1'b0, status_one_addr, 32'h0, rdv, err); endtask : st
   task wr(input logic [31:0] a, d); cpu.xfer(1'b1, a, d, rdv, err); endtask : wr
   task wl(input logic [6:0] f, input logic [5:0] t, input logic h, l);
      @(posedge pclk); queue_fill_count <= f; fill_threshold <= t; st;
      chk("hi", h, rdv[bit_hi]);
      chk("lo", l, rdv[bit_lo]);
   endtask : wl
   task t_water;
      wl(7'h3c, 6'h04, 1, 0); wl(7'h3b, 6'h04, 0, 0); wl(7'h04, 6'h04, 0, 1); wl(7'h05, 6'h04, 0, 0);
      wl(7'h40, 6'h00, 1, 0); wl(7'h00, 6'h3f, 0, 1); wl(7'h20, 6'h20, 1, 1);
      $display("t_water done");
   endtask : t_water
   task t_irq;
      @(posedge pclk); {comm_irq_sources, comm_irq_enables, group1_select} <= 24'h010101;
      {cpu_irq_enable_group1, cpu_irq_enable_group0} <= 2'b11; st;
      chk("g1", 1, rdv[bit_irq1]); chk("g0", 0, rdv[bit_irq0]); chk("c1", 1, cpu_irq_group1);
      @(posedge pclk); group1_select <= 8'h00; cpu_irq_enable_group0 <= 1'b0; st;
      chk("g1", 0, rdv[bit_irq1]); chk("g0", 1, rdv[bit_irq0]); chk("c0", 0, cpu_irq_group0);
      chk("c1", 0, cpu_irq_group1);
      @(posedge pclk); cpu_irq_enable_group0 <= 1'b1; st;
      chk("c0", 1, cpu_irq_group0);
      @(posedge pclk); comm_irq_enables <= 8'h00; misc_irq_sources <= 8'h80; st;
      chk("g0", 0, rdv[bit_irq0]); chk("c0", 0, cpu_irq_group0);
      // misc sources reach group 1 only through their own enables
      @(posedge pclk); misc_irq_enables <= 8'h80; group1_select <= 8'h80; st;
      chk("g1", 1, rdv[bit_irq1]); chk("g0", 0, rdv[bit_irq0]);
      @(posedge pclk); misc_irq_enables <= 8'h00;
      $display("t_irq done");
   endtask : t_irq
   task t_misc;
      @(posedge pclk); countdown_enable <= 1'b1; countdown_gate <= 1'b1; field_detect_pin <= 1'b1; st;
      chk("run", 1, rdv[bit_running]); chk("field", 1, rdv[bit_field]);
      // enable high with the gate low must still read running
      @(posedge pclk); countdown_gate <= 1'b0; st;
      chk("run", 1, rdv[bit_running]);
      @(posedge pclk); countdown_enable <= 1'b0; countdown_gate <= 1'b1; field_detect_pin <= 1'b0; st;
      chk("run", 0, rdv[bit_running]); chk("field", 0, rdv[bit_field]);
      @(posedge pclk); checksum_compute_cmd <= 1'b1; checksum_busy <= 1'b1; st;
      chk("done", 0, rdv[bit_crc_done]);
      @(posedge pclk); {checksum_busy, checksum_result_zero, checksum_finish} <= 3'b011;
      @(posedge pclk); checksum_finish <= 1'b0; st;
      chk("zero", 1, rdv[bit_crc_zero]); chk("done", 1, rdv[bit_crc_done]);
      // zero flag is high here, so a missing clear while busy would show
      @(posedge pclk); checksum_busy <= 1'b1; st;
      chk("zero", 0, rdv[bit_crc_zero]); chk("done", 0, rdv[bit_crc_done]);
      @(posedge pclk); {checksum_busy, checksum_result_zero, checksum_finish} <= 3'b001;
      @(posedge pclk); checksum_finish <= 1'b0; st;
      chk("zero", 0, rdv[bit_crc_zero]); chk("done", 1, rdv[bit_crc_done]);
      $display("t_misc done");
   endtask : t_misc
   task t_regs;
      // done, high and low marks set; every other status bit clear, irq sources still high but not enabled
      wr(status_one_addr, 32'hff); chk("ro err", 1, err);
      st; chk("st", 32'h23, rdv);
      cpu.xfer(1'b0, 32'h0000_0040, 32'h0, rdv, err); chk("unmapped", 1, err);
      chk("unmapped data", 32'h0, rdv);
      wr(irq_status_addr, 32'hff); wr(irq_mask_addr, 32'h04);
      cpu.xfer(1'b0, irq_mask_addr, 32'h0, rdv, err); chk("mask", 32'h04, rdv);
      chk("mask err", 0, err);
      @(posedge pclk); field_detect_pin <= 1'b1; st; chk("irq", 1, irq);
      wr(irq_status_addr, 32'h04); repeat (2) @(posedge pclk); chk("irq", 0, irq);
      wr(irq_mask_addr, 32'h00); @(posedge pclk); field_detect_pin <= 1'b0; st;
      @(posedge pclk); field_detect_pin <= 1'b1; st; chk("irq", 0, irq);
      // masked event still sticks in the status word
      cpu.xfer(1'b0, irq_status_addr, 32'h0, rdv, err); chk("event", 32'h04, rdv);
      $display("t_regs done");
   endtask : t_regs
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      st; chk("st", 32'h21, rdv);
      t_water; t_irq; t_misc; t_regs;
      stop_test;
   end
endmodule : tb_top
`default_nettype wire
